/* logic/lpw_dev.sv */
// low power mode release and oscillator warm-up controller, device end
//
// Overview of operation
// - leave low power on irq, nmi, reset
// - interrupt wake resumes clocks, then handling starts
// - watchdog nmi wakes only from idle
// - nmi pin wakes every low power mode
// - system tick wakes only from idle
// - software enables cpu and cg detection
// - software masks all non-release interrupts
// - level sources hold until handling starts
// - reset pin forces normal, clears everything
// - reset gives no warm-up; hold reset long
// - stop or sleep to normal auto warm-up
// - software sets oscillator and time beforehand
// - pll off in stop and sleep
// - normal to slow needs software warm-up
// - slow to normal needs software warm-up
// - stop to slow uses pre-stop warm-up time
// - slow sleep slow resumes without warm-up
// - standby codes stop 001, sleep 010, idle 011
// - return to previous normal or slow mode
// - idle stops cpu only; stop halts oscillators
`timescale 1ns/1ps
module lpw_dev
  import lpw_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  lpw_link_if.dev link,
  output logic cpu_clk_en,
  output logic sysclk_en,
  output logic pll_en,
  output logic hs_osc_run,
  output logic ls_osc_run
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lpw_state_e state;
  lpw_state_e next_state;
  logic ret_slow;
  logic next_ret_slow;
  logic [WARM_W-1:0] cnt;
  logic [WARM_W-1:0] next_cnt;
  logic [WARM_W-1:0] target;
  logic [WARM_W-1:0] next_target;
  logic sel;
  logic next_sel;
  logic sww;
  logic next_sww;
  logic [1:0] cause;
  logic [1:0] next_cause;
  logic irq_start;
  logic next_irq_start;
  logic next_cpu_clk_en;
  logic next_sysclk_en;
  logic next_pll_en;
  logic next_hs_run;
  logic next_ls_run;

  logic tick;
  logic irq_idle;
  logic irq_sleep;
  logic irq_stop;
  logic nmi_idle;
  logic nmi_deep;

  // ----------------------------------------------------------------
  // wake source qualification
  // ----------------------------------------------------------------
  // the counter advances only on the oscillator picked for warm-up
  assign tick = sel ? link.ls_tick : link.hs_tick;
  // idle takes every enabled source, including the system tick
  assign irq_idle = (|link.external_irq_pins) | link.rtc_irq | link.periph_irq
                    | link.system_tick_interrupt;
  // sleep and stop also need the clock generator's own detect enable
  assign irq_sleep = (|(link.external_irq_pins & link.cg_irq_enable))
                     | (link.rtc_irq & link.cg_rtc_enable);
  assign irq_stop = |(link.external_irq_pins & link.cg_irq_enable);
  // watchdog nmi only counts while idle; the pin counts always
  assign nmi_idle = link.nmi_pin | link.watchdog_nmi_request;
  assign nmi_deep = link.nmi_pin;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_ret_slow = ret_slow;
    next_cnt = cnt;
    next_target = target;
    next_sel = sel;
    next_sww = sww;
    next_cause = cause;
    next_irq_start = 1'b0;
    case (state)
      ST_NORMAL, ST_SLOW:
      begin
        next_state = link.run_slow ? ST_SLOW : ST_NORMAL;
        // software warm-up before a clock switch; status only
        if (sww)
        begin
          if (cnt >= target)
          begin
            next_sww = 1'b0;
          end
          else if (tick)
          begin
            next_cnt = cnt + 12'h001;
          end
        end
        else if (link.sw_warmup_start)
        begin
          next_sww = 1'b1;
          next_cnt = '0;
          next_target = lpw_warm_ticks(link.warmup_time_field);
          next_sel = link.warmup_osc_select;
        end
        // entry: settings are frozen now so a later write cannot alter the wake
        if (link.wait_for_interrupt_instr)
        begin
          case (link.standby_mode)
            STBY_IDLE: next_state = ST_IDLE;
            STBY_SLEEP: next_state = ST_SLEEP;
            STBY_STOP: next_state = ST_STOP;
            default: next_state = state;
          endcase
          if (link.standby_mode == STBY_IDLE || link.standby_mode == STBY_SLEEP
              || link.standby_mode == STBY_STOP)
          begin
            next_ret_slow = (state == ST_SLOW);
            next_cnt = '0;
            next_target = lpw_warm_ticks(link.warmup_time_field);
            next_sel = link.warmup_osc_select;
            next_sww = 1'b0;
            next_cause = CAUSE_NONE;
          end
        end
      end
      ST_IDLE:
      begin
        // oscillators still run, so resume at once
        if (irq_idle || nmi_idle)
        begin
          next_state = ret_slow ? ST_SLOW : ST_NORMAL;
          next_irq_start = 1'b1;
          next_cause = nmi_idle ? CAUSE_NMI : CAUSE_IRQ;
        end
      end
      ST_SLEEP:
      begin
        if (irq_sleep || nmi_deep)
        begin
          next_cause = nmi_deep ? CAUSE_NMI : CAUSE_IRQ;
          if (ret_slow)
          begin
            // low-speed oscillator kept running through sleep
            next_state = ST_SLOW;
            next_irq_start = 1'b1;
          end
          else
          begin
            next_state = ST_WARM;
          end
        end
      end
      ST_STOP:
      begin
        if (irq_stop || nmi_deep)
        begin
          next_cause = nmi_deep ? CAUSE_NMI : CAUSE_IRQ;
          next_state = ST_WARM;
        end
      end
      ST_WARM:
      begin
        // wake inputs are not looked at here, so nothing restarts the count
        if (cnt >= target)
        begin
          next_state = ret_slow ? ST_SLOW : ST_NORMAL;
          next_irq_start = 1'b1;
        end
        else if (tick)
        begin
          next_cnt = cnt + 12'h001;
        end
      end
      default:
      begin
        next_state = ST_NORMAL;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // clock and oscillator controls, derived from the next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cpu_clk_en = (next_state == ST_NORMAL) || (next_state == ST_SLOW);
    // system clock stays gated through sleep, stop and warm-up
    next_sysclk_en = (next_state == ST_NORMAL) || (next_state == ST_SLOW)
                     || (next_state == ST_IDLE);
    // pll restarts during a warm-up toward normal so it locks in time
    next_pll_en = (next_state == ST_NORMAL) || (next_state == ST_IDLE)
                  || (next_state == ST_WARM && !next_ret_slow);
    next_hs_run = (next_state == ST_NORMAL) || (next_state == ST_IDLE)
                  || (next_state == ST_SLOW && link.hs_osc_enable)
                  || (next_state == ST_WARM && !next_ret_slow);
    next_ls_run = (next_state == ST_SLOW) || (next_state == ST_SLEEP)
                  || (next_state == ST_WARM && next_ret_slow)
                  || ((next_state == ST_NORMAL || next_state == ST_IDLE) && link.ls_osc_enable);
  end

  // ----------------------------------------------------------------
  // registers; reset pin lands in normal with no warm-up
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= ST_NORMAL;
      ret_slow <= 1'b0;
      cnt <= '0;
      target <= WARM_BASE_TICKS;
      sel <= 1'b0;
      sww <= 1'b0;
      cause <= CAUSE_NONE;
      irq_start <= 1'b0;
      cpu_clk_en <= 1'b1;
      sysclk_en <= 1'b1;
      pll_en <= 1'b1;
      hs_osc_run <= 1'b1;
      ls_osc_run <= 1'b1;
    end
    else
    begin
      state <= next_state;
      ret_slow <= next_ret_slow;
      cnt <= next_cnt;
      target <= next_target;
      sel <= next_sel;
      sww <= next_sww;
      cause <= next_cause;
      irq_start <= next_irq_start;
      cpu_clk_en <= next_cpu_clk_en;
      sysclk_en <= next_sysclk_en;
      pll_en <= next_pll_en;
      hs_osc_run <= next_hs_run;
      ls_osc_run <= next_ls_run;
    end
  end

  // status back to the core side
  assign link.mode_state = state;
  assign link.warmup_busy = sww || (state == ST_WARM);
  assign link.wake_cause = cause;
  assign link.irq_start = irq_start;

endmodule // lpw_dev

/* common/lpw_pkg.sv */
// constants and types shared by the low power wake and warm-up controller ends
package lpw_pkg;
  // standby field codes
  localparam logic [2:0] STBY_STOP = 3'h1;
  localparam logic [2:0] STBY_SLEEP = 3'h2;
  localparam logic [2:0] STBY_IDLE = 3'h3;
  // wake cause codes
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_IRQ = 2'h1;
  localparam logic [1:0] CAUSE_NMI = 2'h2;
  // warm-up timing: ticks = base << field
  localparam int WARM_W = 12;
  localparam logic [11:0] WARM_BASE_TICKS = 12'h010;
  localparam int PLL_LOCK_US = 200;
  localparam int CLK_MHZ = 40;
  localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
  // oscillator tick dividers, in hclk cycles
  localparam logic [3:0] HS_TICK_DIV = 4'h2;
  localparam logic [3:0] LS_TICK_DIV = 4'h8;
  // register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CMD = 4'h4;
  localparam logic [3:0] OFS_WAKE = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;
  // control register fields and reset value
  localparam int CTRL_STBY_LSB = 0;
  localparam int CTRL_WSEL_BIT = 3;
  localparam int CTRL_WTIME_LSB = 4;
  localparam int CTRL_SLOW_BIT = 7;
  localparam int CTRL_LSEN_BIT = 8;
  localparam int CTRL_HSEN_BIT = 9;
  localparam logic [9:0] CTRL_RESET = 10'h300;
  // command register bits
  localparam int CMD_WFI_BIT = 0;
  localparam int CMD_SWW_BIT = 1;
  // wake enable register fields and reset value
  localparam int WAKE_CPU_LSB = 0;
  localparam int WAKE_CG_LSB = 8;
  localparam int WAKE_CPU_RTC_BIT = 16;
  localparam int WAKE_CG_RTC_BIT = 17;
  localparam int WAKE_PERIPH_BIT = 18;
  localparam int WAKE_TICK_BIT = 19;
  localparam logic [19:0] WAKE_RESET = 20'h00000;
  // status register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_CAUSE_LSB = 9;
  localparam int STAT_RESUME_BIT = 11;

  typedef enum logic [5:0] {
    ST_NORMAL = 6'h01,
    ST_SLOW = 6'h02,
    ST_IDLE = 6'h04,
    ST_SLEEP = 6'h08,
    ST_STOP = 6'h10,
    ST_WARM = 6'h20
  } lpw_state_e;

  // warm-up length in oscillator ticks for a three-bit field
  function automatic logic [11:0] lpw_warm_ticks(input logic [2:0] field);
    lpw_warm_ticks = WARM_BASE_TICKS << field;
  endfunction
endpackage

/* common/lpw_link_if.sv */
// link between the wake controller and its core and source side
`timescale 1ns/1ps
interface lpw_link_if;
  logic [2:0] standby_mode;
  logic warmup_osc_select;
  logic [2:0] warmup_time_field;
  logic wait_for_interrupt_instr;
  logic sw_warmup_start;
  logic run_slow;
  logic ls_osc_enable;
  logic hs_osc_enable;
  logic hs_tick;
  logic ls_tick;
  logic [7:0] external_irq_pins;
  logic [7:0] cg_irq_enable;
  logic rtc_irq;
  logic cg_rtc_enable;
  logic periph_irq;
  logic system_tick_interrupt;
  logic watchdog_nmi_request;
  logic nmi_pin;
  logic [5:0] mode_state;
  logic warmup_busy;
  logic [1:0] wake_cause;
  logic irq_start;

  modport dev (
    input standby_mode, warmup_osc_select, warmup_time_field, wait_for_interrupt_instr,
    input sw_warmup_start, run_slow, ls_osc_enable, hs_osc_enable, hs_tick, ls_tick,
    input external_irq_pins, cg_irq_enable, rtc_irq, cg_rtc_enable, periph_irq,
    input system_tick_interrupt, watchdog_nmi_request, nmi_pin,
    output mode_state, warmup_busy, wake_cause, irq_start
  );
  modport ctl (
    output standby_mode, warmup_osc_select, warmup_time_field, wait_for_interrupt_instr,
    output sw_warmup_start, run_slow, ls_osc_enable, hs_osc_enable, hs_tick, ls_tick,
    output external_irq_pins, cg_irq_enable, rtc_irq, cg_rtc_enable, periph_irq,
    output system_tick_interrupt, watchdog_nmi_request, nmi_pin,
    input mode_state, warmup_busy, wake_cause, irq_start
  );
endinterface

/* logic/lpw_ctl.sv */
// core side: ahb-lite registers, source synchronisers, oscillator ticks
`timescale 1ns/1ps
module lpw_ctl
  import lpw_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] ext_irq_pins,
  input wire logic rtc_irq,
  input wire logic periph_irq,
  input wire logic system_tick_interrupt,
  input wire logic watchdog_nmi_request,
  input wire logic nmi_pin,
  lpw_link_if.ctl link
);

  // ----------------------------------------------------------------
  // bus and register state
  // ----------------------------------------------------------------
  logic [9:0] ctrl;
  logic [9:0] next_ctrl;
  logic [19:0] wake;
  logic [19:0] next_wake;
  logic [1:0] cmd;
  logic [1:0] next_cmd;
  logic resume;
  logic next_resume;
  logic wr_pend;
  logic next_wr_pend;
  logic [3:0] wr_ofs;
  logic [3:0] next_wr_ofs;
  logic [31:0] next_hrdata;
  logic [31:0] stat;
  logic take;
  logic [12:0] sync1;
  logic [12:0] sync2;
  logic [12:0] srcs;
  logic [12:0] next_srcs;
  logic [3:0] hs_div;
  logic [3:0] ls_div;
  logic [3:0] next_hs_div;
  logic [3:0] next_ls_div;
  logic hs_tick;
  logic ls_tick;

  assign take = hsel && htrans[1] && hready;
  assign stat = {20'h00000, resume, link.wake_cause, link.warmup_busy, 2'h0, link.mode_state};

  // ----------------------------------------------------------------
  // register decode; zero wait states, writes land in the data phase
  // ----------------------------------------------------------------
  always_comb
  begin
    next_ctrl = ctrl;
    next_wake = wake;
    next_cmd = 2'h0;
    next_wr_pend = take && hwrite;
    next_wr_ofs = haddr[3:0];
    next_hrdata = hrdata;
    // a resume in the same cycle as its clear keeps the flag set
    next_resume = resume;
    if (wr_pend)
    begin
      case (wr_ofs)
        OFS_CTRL: next_ctrl = hwdata[9:0];
        OFS_CMD: next_cmd = hwdata[1:0];
        OFS_WAKE: next_wake = hwdata[19:0];
        OFS_STAT: next_resume = resume && !hwdata[STAT_RESUME_BIT];
        default: next_ctrl = ctrl;
      endcase
    end
    if (link.irq_start)
    begin
      next_resume = 1'b1;
    end
    if (take && !hwrite)
    begin
      case (haddr[3:0])
        OFS_CTRL: next_hrdata = {22'h000000, ctrl};
        OFS_WAKE: next_hrdata = {12'h000, wake};
        OFS_STAT: next_hrdata = stat;
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= CTRL_RESET;
      wake <= WAKE_RESET;
      cmd <= 2'h0;
      resume <= 1'b0;
      wr_pend <= 1'b0;
      wr_ofs <= 4'h0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      wake <= next_wake;
      cmd <= next_cmd;
      resume <= next_resume;
      wr_pend <= next_wr_pend;
      wr_ofs <= next_wr_ofs;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and cpu-side interrupt masking
  // ----------------------------------------------------------------
  // unmasked sources would wake the device unintentionally
  always_comb
  begin
    next_srcs[7:0] = sync2[7:0] & wake[WAKE_CPU_LSB +: 8];
    next_srcs[8] = sync2[8] & wake[WAKE_CPU_RTC_BIT];
    next_srcs[9] = sync2[9] & wake[WAKE_PERIPH_BIT];
    next_srcs[10] = sync2[10] & wake[WAKE_TICK_BIT];
    next_srcs[12:11] = sync2[12:11]; // nmi sources cannot be masked
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1 <= 13'h0000;
      sync2 <= 13'h0000;
      srcs <= 13'h0000;
    end
    else
    begin
      sync1 <= {nmi_pin, watchdog_nmi_request, system_tick_interrupt, periph_irq, rtc_irq, ext_irq_pins};
      sync2 <= sync1;
      srcs <= next_srcs;
    end
  end

  // ----------------------------------------------------------------
  // oscillator tick dividers
  // ----------------------------------------------------------------
  always_comb
  begin
    next_hs_div = (hs_div == HS_TICK_DIV - 4'h1) ? 4'h0 : hs_div + 4'h1;
    next_ls_div = (ls_div == LS_TICK_DIV - 4'h1) ? 4'h0 : ls_div + 4'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hs_div <= 4'h0;
      ls_div <= 4'h0;
      hs_tick <= 1'b0;
      ls_tick <= 1'b0;
    end
    else
    begin
      hs_div <= next_hs_div;
      ls_div <= next_ls_div;
      hs_tick <= (hs_div == HS_TICK_DIV - 4'h1);
      ls_tick <= (ls_div == LS_TICK_DIV - 4'h1);
    end
  end

  // link drive; every term comes from a register above
  assign link.standby_mode = ctrl[CTRL_STBY_LSB +: 3];
  assign link.warmup_osc_select = ctrl[CTRL_WSEL_BIT];
  assign link.warmup_time_field = ctrl[CTRL_WTIME_LSB +: 3];
  assign link.run_slow = ctrl[CTRL_SLOW_BIT];
  assign link.ls_osc_enable = ctrl[CTRL_LSEN_BIT];
  assign link.hs_osc_enable = ctrl[CTRL_HSEN_BIT];
  assign link.wait_for_interrupt_instr = cmd[CMD_WFI_BIT];
  assign link.sw_warmup_start = cmd[CMD_SWW_BIT];
  assign link.hs_tick = hs_tick;
  assign link.ls_tick = ls_tick;
  assign link.external_irq_pins = srcs[7:0];
  assign link.cg_irq_enable = wake[WAKE_CG_LSB +: 8];
  assign link.rtc_irq = srcs[8];
  assign link.cg_rtc_enable = wake[WAKE_CG_RTC_BIT];
  assign link.periph_irq = srcs[9];
  assign link.system_tick_interrupt = srcs[10];
  assign link.watchdog_nmi_request = srcs[11];
  assign link.nmi_pin = srcs[12];

endmodule // lpw_ctl

/* tb/lpw_asserts.sv */
// concurrent checks on the link between the two controller ends
`timescale 1ns/1ps
module lpw_asserts
  import lpw_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] standby_mode,
  input wire logic warmup_osc_select,
  input wire logic [2:0] warmup_time_field,
  input wire logic wait_for_interrupt_instr,
  input wire logic [7:0] external_irq_pins,
  input wire logic [7:0] cg_irq_enable,
  input wire logic rtc_irq,
  input wire logic cg_rtc_enable,
  input wire logic system_tick_interrupt,
  input wire logic watchdog_nmi_request,
  input wire logic nmi_pin,
  input wire logic [5:0] mode_state,
  input wire logic warmup_busy,
  input wire logic irq_start
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic [15:0] wcnt, next_wcnt, tks, div, lo, hi;
  logic [2:0] fld, next_fld;
  logic sel, next_sel, slow, next_slow, lp_ok, deep, cg_wake, warm;
  logic [5:0] want;

  // entry decode and the wakes the clock generator can see
  assign warm = mode_state == ST_WARM;
  assign deep = mode_state == ST_STOP || mode_state == ST_SLEEP;
  assign lp_ok = wait_for_interrupt_instr && (mode_state == ST_NORMAL || mode_state == ST_SLOW)
                 && standby_mode inside {STBY_STOP, STBY_SLEEP, STBY_IDLE};
  assign want = (standby_mode == STBY_STOP) ? ST_STOP : (standby_mode == STBY_SLEEP) ? ST_SLEEP : ST_IDLE;
  assign cg_wake = |(external_irq_pins & cg_irq_enable) || nmi_pin
                   || (rtc_irq && cg_rtc_enable && mode_state == ST_SLEEP);
  // tick phase is unknown: one tick of slack below, four cycles above
  assign tks = 16'(WARM_BASE_TICKS) << fld;
  assign div = sel ? 16'(LS_TICK_DIV) : 16'(HS_TICK_DIV);
  assign lo = (tks - 16'h1) * div;
  assign hi = tks * div + 16'h4;
  // warm cycle count and settings latched at entry
  always_comb
  begin
    next_wcnt = warm ? wcnt + 16'h1 : 16'h0;
    next_fld = lp_ok ? warmup_time_field : fld;
    next_sel = lp_ok ? warmup_osc_select : sel;
    next_slow = lp_ok ? (mode_state == ST_SLOW) : slow;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wcnt <= 16'h0;
      fld <= 3'h0;
      sel <= 1'b0;
      slow <= 1'b0;
    end
    else
    begin
      wcnt <= next_wcnt;
      fld <= next_fld;
      sel <= next_sel;
      slow <= next_slow;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence warm_done_s;
    wcnt != 16'h0 && !warm;
  endsequence
  reset_normal_a:
    assert property ($rose(hresetn) |-> mode_state == ST_NORMAL && !warmup_busy) else $error("not normal after reset");
  entry_map_a:
    assert property (lp_ok |=> mode_state == $past(want)) else $error("wrong low power entry");
  quiet_stay_a:
    assert property (deep && !cg_wake |=> $stable(mode_state)) else $error("woke on ignored source");
  idle_wake_a:
    assert property (mode_state == ST_IDLE && (system_tick_interrupt || watchdog_nmi_request || nmi_pin)
                     |=> mode_state != ST_IDLE && irq_start) else $error("idle did not wake");
  deep_warm_a:
    assert property (deep && cg_wake && !(mode_state == ST_SLEEP && slow) |=> warm) else $error("no warm-up");
  slow_sleep_a:
    assert property (mode_state == ST_SLEEP && slow && cg_wake |=> mode_state == ST_SLOW && irq_start)
      else $error("slow sleep return wrong");
  warm_busy_a:
    assert property (warm |-> warmup_busy && !irq_start) else $error("warm-up not held");
  warm_len_a:
    assert property (warm_done_s |-> wcnt >= lo && wcnt <= hi) else $error("warm-up length wrong");
  warm_exit_a:
    assert property (warm_done_s |-> irq_start && mode_state == (slow ? ST_SLOW : ST_NORMAL))
      else $error("warm-up exit wrong");
endmodule // lpw_asserts

/* tb/low_power_wake_warmup_ctrl_tb.sv */
// self-checking bench for the wake and warm-up controller pair
`timescale 1ns/1ps
module low_power_wake_warmup_ctrl_tb
  import lpw_pkg::*;
;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, dph = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, lfsr = 32'hc566, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, pin = 3'h0;
  logic hreadyout, hresp, cpu_clk_en, sysclk_en, pll_en, hs_osc_run, ls_osc_run;
  logic [5:0] src_v = 6'h0;
  logic [2:0] bad[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [63:0] notes[$];
  int mismatches = 0, checks = 0, cyc = 0;

  always #12.5 hclk = ~hclk;

  lpw_link_if link_bus ();
  lpw_dev lpw_dev_inst (.hclk(hclk), .hresetn(hresetn), .link(link_bus), .cpu_clk_en(cpu_clk_en),
    .sysclk_en(sysclk_en), .pll_en(pll_en), .hs_osc_run(hs_osc_run), .ls_osc_run(ls_osc_run));
  lpw_ctl lpw_ctl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pins(src_v[0] ? (8'h1 << pin) : 8'h0),
    .rtc_irq(src_v[1]), .periph_irq(src_v[2]), .system_tick_interrupt(src_v[3]),
    .watchdog_nmi_request(src_v[4]), .nmi_pin(src_v[5]), .link(link_bus));
  lpw_asserts lpw_asserts_inst (.hclk(hclk), .hresetn(hresetn), .standby_mode(link_bus.standby_mode),
    .warmup_osc_select(link_bus.warmup_osc_select), .warmup_time_field(link_bus.warmup_time_field),
    .wait_for_interrupt_instr(link_bus.wait_for_interrupt_instr), .external_irq_pins(link_bus.external_irq_pins),
    .cg_irq_enable(link_bus.cg_irq_enable), .rtc_irq(link_bus.rtc_irq), .cg_rtc_enable(link_bus.cg_rtc_enable),
    .system_tick_interrupt(link_bus.system_tick_interrupt), .watchdog_nmi_request(link_bus.watchdog_nmi_request),
    .nmi_pin(link_bus.nmi_pin), .mode_state(link_bus.mode_state), .warmup_busy(link_bus.warmup_busy),
    .irq_start(link_bus.irq_start));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction
  task automatic final_report();
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // single transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {28'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  // a zero mask marks a poll whose data is not compared
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, output logic [31:0] d);
    notes.push_back({m, e});
    bus(1'b0, a, 32'h0, d);
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [63:0] n);
    if (n[63:32] != 32'h0)
    begin
      checks++;
      if ((got & n[63:32]) !== (n[31:0] & n[63:32]) || hresp !== 1'b0)
      begin
        mismatches++;
        $display("[ERR] %0t read %h expected %h", $time, got, n[31:0]);
      end
    end
  endtask
  task automatic chk_bit(input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t clock enables %b expected %b", $time, got, exp);
    end
  endtask
  // one low power trip: ignored sources first, then the real wake
  task automatic lp_run(input logic slow, input logic [2:0] stby, input logic [5:0] ign, input logic [5:0] src,
                        input logic [1:0] cause, input logic [4:0] osc);
    logic [31:0] d;
    logic [5:0] lp;
    int n;
    lfsr = lfsr_next(lfsr);
    pin <= lfsr[6:4];
    lp = (stby == STBY_STOP) ? ST_STOP : (stby == STBY_SLEEP) ? ST_SLEEP : ST_IDLE;
    wr(OFS_CTRL, {22'h0, 2'h3, slow, 1'b0, lfsr[1], lfsr[0] & ~lfsr[1], lfsr[2], stby});
    wr(OFS_STAT, 32'h800);
    wr(OFS_CMD, 32'h1);
    repeat (3) @(posedge hclk);
    rd(OFS_STAT, '1, {26'h0, lp}, d);
    chk_bit({cpu_clk_en, sysclk_en, pll_en, hs_osc_run, ls_osc_run}, osc);
    src_v <= ign;
    repeat (20) @(posedge hclk);
    rd(OFS_STAT, '1, {26'h0, lp}, d);
    src_v <= src;
    n = 0;
    do
    begin
      rd(OFS_STAT, 32'h0, 32'h0, d);
      n++;
    end
    while (d[11] !== 1'b1 && n < 400);
    src_v <= 6'h0;
    rd(OFS_STAT, '1, {20'h0, 1'b1, cause, 3'h0, slow ? ST_SLOW : ST_NORMAL}, d);
  endtask

  // ----------------------------------------
  // result watcher, timeout and main sequence
  // ----------------------------------------
  always @(posedge hclk)
  begin
    if (dph && hreadyout === 1'b1 && notes.size() > 0)
      chk_rd(hrdata, notes.pop_front());
    dph <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      final_report();
    end
  end

  initial
  begin
    logic [31:0] d;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_CTRL, '1, 32'h300, d);
    rd(OFS_WAKE, '1, 32'h0, d);
    rd(OFS_CMD, '1, 32'h0, d);
    rd(OFS_STAT, '1, 32'h1, d);
    wr(OFS_WAKE, 32'hfffff);
    foreach (bad[i])
    begin
      wr(OFS_CTRL, {22'h0, 7'h62, bad[i]});
      wr(OFS_CMD, 32'h3);
      repeat (3) @(posedge hclk);
      rd(OFS_STAT, '1, 32'h101, d);
    end
    repeat (30) @(posedge hclk);
    rd(OFS_STAT, '1, 32'h1, d);
    lp_run(1'b0, STBY_STOP, 6'h1e, 6'h01, CAUSE_IRQ, 5'h00);
    lp_run(1'b0, STBY_SLEEP, 6'h1c, 6'h02, CAUSE_IRQ, 5'h01);
    lp_run(1'b1, STBY_SLEEP, 6'h1c, 6'h20, CAUSE_NMI, 5'h01);
    lp_run(1'b1, STBY_STOP, 6'h1e, 6'h01, CAUSE_IRQ, 5'h00);
    lp_run(1'b0, STBY_IDLE, 6'h00, 6'h10, CAUSE_NMI, 5'h0f);
    lp_run(1'b0, STBY_IDLE, 6'h00, 6'h08, CAUSE_IRQ, 5'h0f);
    lp_run(1'b0, STBY_IDLE, 6'h00, 6'h04, CAUSE_IRQ, 5'h0f);
    lp_run(1'b0, STBY_STOP, 6'h1e, 6'h20, CAUSE_NMI, 5'h00);
    wr(OFS_CTRL, 32'h301);
    wr(OFS_CMD, 32'h1);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_bit({cpu_clk_en, sysclk_en, pll_en, hs_osc_run, ls_osc_run}, 5'h1f);
    rd(OFS_STAT, '1, 32'h1, d);
    rd(OFS_CTRL, '1, 32'h300, d);
    repeat (4) @(posedge hclk);
    final_report();
  end
endmodule // low_power_wake_warmup_ctrl_tb
